// ### src/drt_refresh_ctrl.sv
// Refresh timer, refresh sequencer and strobe option logic with an APB register port
`timescale 1ns/1ps
`include "drt_defines.svh"

// How it works
// R01: RAS down mode raises RAS when access pauses
// R02: RAS up mode keeps RAS low between accesses
// R03: Burst bit selects full or page/column access
// R04: Precharge bit selects one or two states
// R05: Burst and precharge apply to memory areas only
// R06: Clock select stops or divides counter clock
// R07: Match interrupt only while enable bit set; irq still fires on a match through iStat_ff and iMask_ff with it clear
// R08: Match flag set when counter equals period
// R09: Flag cleared by zero write after reading one
// R10: Mode bit picks CBR/auto or self refresh
// R11: Wait bit adds one refresh wait state
// R12: No refresh control while enable is zero
// R13: Counter is 8-bit readable writable up-counter
// R14: Match starts refresh when refresh enabled
// R15: Match clears counter when refresh enabled
// R16: Period register sets compare match period
// R17: Refresh wait field adds zero to three
// R18: Pending refresh runs before next access
module drt_refresh_ctrl
  import drt_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire drt_apb_req_s apbReq,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic accReq,
  output logic accAck,
  output drt_strobe_s memStrobe,
  output logic refreshBusy,
  output logic matchIrq,
  output logic irq
);

  // ***************************************************
  // Registers
  // ***************************************************
  logic [7:0] ctrl_ff;
  logic [7:0] count_ff;
  logic [7:0] period_ff;
  logic [7:0] memCtl_ff;
  logic [1:0] area_ff;
  logic [1:0] iStat_ff;
  logic [1:0] iMask_ff;
  logic flagArmed_ff;
  logic matchLast_ff;
  logic refPend_ff;
  logic [11:0] pre_ff;
  logic [2:0] waitCnt_ff;
  drt_state_e state_ff;
  logic [31:0] prdata_ff;
  drt_strobe_s strobe_ff;
  logic refBusy_ff;

  // ***************************************************
  // APB decode
  // ***************************************************
  wire setupPh = apbReq.psel & ~apbReq.penable;
  wire accessPh = apbReq.psel & apbReq.penable;
  wire selCtrl = apbReq.paddr == `DRT_OFS_CTRL;
  wire selCount = apbReq.paddr == `DRT_OFS_COUNT;
  wire selPeriod = apbReq.paddr == `DRT_OFS_PERIOD;
  wire selMem = apbReq.paddr == `DRT_OFS_MEMCTL;
  wire selArea = apbReq.paddr == `DRT_OFS_AREA;
  wire selIStat = apbReq.paddr == `DRT_OFS_ISTAT;
  wire selIMask = apbReq.paddr == `DRT_OFS_IMASK;
  wire selState = apbReq.paddr == `DRT_OFS_STATE;
  wire mapped = selCtrl | selCount | selPeriod | selMem | selArea | selIStat | selIMask
                | selState;
  wire wrEn = accessPh & apbReq.pwrite & mapped;
  wire wrCtrl = wrEn & selCtrl;
  wire wrCount = wrEn & selCount;
  wire rdCtrl = accessPh & ~apbReq.pwrite & selCtrl;
  wire [7:0] wd = apbReq.pwdata[7:0];

  // Read data is latched in setup, so the answer always comes in the access cycle
  assign pready = accessPh;
  assign pslverr = accessPh & ~mapped;
  assign prdata = prdata_ff;

  // Read mux: narrow registers sit in the low bits, upper bits read zero
  wire [31:0] rdMux = selCtrl ? {24'h0, ctrl_ff}
                    : selCount ? {24'h0, count_ff}
                    : selPeriod ? {24'h0, period_ff}
                    : selMem ? {24'h0, memCtl_ff}
                    : selArea ? {30'h0, area_ff}
                    : selIStat ? {30'h0, iStat_ff}
                    : selIMask ? {30'h0, iMask_ff}
                    : selState ? {27'h0, refPend_ff, 1'b0, state_ff}
                    : 32'h0;

  // ***************************************************
  // Control fields
  // ***************************************************
  wire refEn = ctrl_ff[`DRT_CTRL_REFEN];
  wire refWaitBit = ctrl_ff[`DRT_CTRL_RWAIT];
  wire refModeSel = ctrl_ff[`DRT_CTRL_RMSEL];
  wire matchFlag = ctrl_ff[`DRT_CTRL_MFLAG];
  wire matchIrqEn = ctrl_ff[`DRT_CTRL_MIEN];
  wire [2:0] cks = ctrl_ff[2:0];
  wire dramSpace = area_ff == `DRT_AREA_DRAM;
  wire memSpace = dramSpace | (area_ff == `DRT_AREA_PSRAM);
  wire burstEff = memCtl_ff[`DRT_MEM_BURST] & memSpace; // R03 R05
  wire [2:0] preLen = (memCtl_ff[`DRT_MEM_PCL] & memSpace) ? `DRT_PRE_LONG
                      : `DRT_PRE_SHORT; // R04 R05
  wire rasDown = memCtl_ff[`DRT_MEM_RASDOWN];
  wire [2:0] rlw = dramSpace ? {1'b0, memCtl_ff[1:0]} : 3'h0; // R17
  wire [2:0] refLen = `DRT_RAS_BASE + rlw + {2'h0, refWaitBit}; // R11

  // ***************************************************
  // Prescaler and compare
  // ***************************************************
  // Divide by 2^(2*cks-1), except 4096 at the top code
  wire [3:0] divLog = (cks == 3'h7) ? 4'hC : ({cks, 1'b0} - 4'h1); // R06
  wire [11:0] divMask = ~(12'hFFF << divLog);
  wire tick = (cks != 3'h0) & ((pre_ff & divMask) == divMask); // R06
  wire matchNow = count_ff == period_ff; // R16
  wire matchRefresh = matchNow & refEn; // R14
  wire matchEvt = matchNow & ~matchLast_ff;
  wire flagClear = wrCtrl & ~wd[`DRT_CTRL_MFLAG] & flagArmed_ff; // R09

  // Software write wins over clear and increment
  wire [7:0] nxt_count = wrCount ? wd
                       : matchRefresh ? 8'h00 // R15
                       : tick ? count_ff + 8'h01 // R13
                       : count_ff;

  // Flag set wins over a same-cycle clear
  wire nxt_flag = matchNow | (matchFlag & ~flagClear); // R08 R09
  wire [7:0] nxt_ctrl = wrCtrl ? {wd[7:5], nxt_flag, wd[3:0]}
                      : {ctrl_ff[7:5], nxt_flag, ctrl_ff[3:0]};

  wire [1:0] iSet = {matchRefresh, matchEvt};
  wire [1:0] iClr = (wrEn & selIStat) ? apbReq.pwdata[1:0] : 2'h0;
  wire [1:0] nxt_iStat = iSet | (iStat_ff & ~iClr);

  // Pending refresh dropped when refresh control is off
  wire refTake = (state_ff == ST_IDLE) & refPend_ff;
  wire nxt_refPend = matchRefresh | (refPend_ff & refEn & ~refTake); // R12 R18

  // Arm on a read that returned the flag set; any control write disarms
  wire nxt_armed = (rdCtrl & prdata_ff[`DRT_CTRL_MFLAG]) | (flagArmed_ff & ~wrCtrl); // R09

  // ***************************************************
  // Access and refresh sequencer
  // ***************************************************
  drt_state_e nxt_state;
  logic [2:0] nxt_wait;

  // Refresh always takes priority over a waiting access
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = waitCnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (refPend_ff) begin
          nxt_state = refModeSel ? ST_SELF : ST_RCAS; // R10 R18
        end else if (accReq) begin
          nxt_state = ST_ROW;
        end
      end
      ST_ROW: begin
        nxt_state = ST_COL;
      end
      ST_COL: begin
        if (burstEff) begin
          nxt_state = ST_PAGE; // R03
        end else begin
          nxt_state = ST_PRE;
          nxt_wait = preLen;
        end
      end
      ST_PAGE: begin
        if (refPend_ff) begin
          nxt_state = ST_PRE; // R18
          nxt_wait = preLen;
        end else if (accReq) begin
          nxt_state = ST_COL; // R03
        end else if (rasDown) begin
          nxt_state = ST_PRE; // R01
          nxt_wait = preLen;
        end
      end
      ST_PRE: begin
        if (waitCnt_ff <= 3'h1) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_wait = waitCnt_ff - 3'h1; // R04
        end
      end
      ST_RCAS: begin
        nxt_state = ST_RRAS;
        nxt_wait = refLen; // R11 R17
      end
      ST_RRAS: begin
        if (waitCnt_ff <= 3'h1) begin
          nxt_state = ST_PRE;
          nxt_wait = preLen;
        end else begin
          nxt_wait = waitCnt_ff - 3'h1;
        end
      end
      ST_SELF: begin
        // Held until software leaves self refresh
        if (!refEn || !refModeSel) begin
          nxt_state = ST_PRE;
          nxt_wait = preLen;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Strobes follow the next state so they leave a flip-flop
  wire nxt_ras = (nxt_state == ST_ROW) | (nxt_state == ST_COL) | (nxt_state == ST_PAGE)
               | (nxt_state == ST_RRAS) | (nxt_state == ST_SELF); // R02
  wire nxt_cas = (nxt_state == ST_COL) | (nxt_state == ST_RCAS) | (nxt_state == ST_RRAS)
               | (nxt_state == ST_SELF);
  wire nxt_busy = (nxt_state == ST_RCAS) | (nxt_state == ST_RRAS) | (nxt_state == ST_SELF);

  assign accAck = state_ff == ST_COL;
  assign memStrobe = strobe_ff;
  assign refreshBusy = refBusy_ff;
  assign matchIrq = matchFlag & matchIrqEn; // R07
  assign irq = |(iStat_ff & iMask_ff);

  // ***************************************************
  // Register state
  // ***************************************************
  // Software-writable registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= `DRT_RST_REG8;
      count_ff <= `DRT_RST_REG8;
      period_ff <= `DRT_RST_REG8;
      memCtl_ff <= `DRT_RST_REG8;
      area_ff <= `DRT_AREA_ORDINARY;
      iMask_ff <= `DRT_RST_IRQ2;
    end else begin
      ctrl_ff <= nxt_ctrl;
      count_ff <= nxt_count;
      if (wrEn & selPeriod) period_ff <= wd; // R16
      if (wrEn & selMem) memCtl_ff <= wd;
      if (wrEn & selArea) area_ff <= wd[1:0];
      if (wrEn & selIMask) iMask_ff <= wd[1:0];
    end
  end

  // Event and timing state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      iStat_ff <= `DRT_RST_IRQ2;
      flagArmed_ff <= 1'b0;
      matchLast_ff <= 1'b0;
      refPend_ff <= 1'b0;
      pre_ff <= 12'h000;
      prdata_ff <= 32'h0;
    end else begin
      iStat_ff <= nxt_iStat;
      flagArmed_ff <= nxt_armed;
      matchLast_ff <= matchNow;
      refPend_ff <= nxt_refPend;
      pre_ff <= pre_ff + 12'h001;
      if (setupPh) prdata_ff <= rdMux;
    end
  end

  // Sequencer state and strobes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      waitCnt_ff <= 3'h0;
      strobe_ff <= '0;
      refBusy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      waitCnt_ff <= nxt_wait;
      strobe_ff <= '{rasActive: nxt_ras, casActive: nxt_cas};
      refBusy_ff <= nxt_busy;
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  ras_down_a: assert property ( // R01
    state_ff == ST_PAGE && !accReq && rasDown && !refPend_ff |=> state_ff == ST_PRE
      ##[1:2] !memStrobe.rasActive)
    else $error("RAS not released in down mode");
  ras_up_a: assert property ( // R02
    state_ff == ST_PAGE && !accReq && !rasDown && !refPend_ff |=> memStrobe.rasActive)
    else $error("RAS dropped in up mode");
  full_access_a: assert property ( // R03
    state_ff == ST_COL && !burstEff |=> state_ff == ST_PRE)
    else $error("Full access did not precharge");
  long_pre_a: assert property ( // R04
    $rose(state_ff == ST_PRE) && preLen == `DRT_PRE_LONG |-> (state_ff == ST_PRE)[*2])
    else $error("Long precharge too short");
  ordinary_area_a: assert property ( // R05
    !memSpace |-> preLen == `DRT_PRE_SHORT && !burstEff)
    else $error("Options applied to ordinary area");
  stopped_count_a: assert property ( // R06
    cks == 3'h0 && !wrCount && !matchRefresh |=> $stable(count_ff))
    else $error("Counter moved while stopped");
  match_irq_a: assert property ( // R07
    !matchIrqEn |-> !matchIrq)
    else $error("Match interrupt while disabled");
  match_flag_a: assert property ( // R08
    matchNow |=> matchFlag)
    else $error("Match flag not set");
  flag_keep_a: assert property ( // R09
    matchFlag && !flagArmed_ff |=> matchFlag)
    else $error("Match flag cleared without read");
  no_refresh_a: assert property ( // R12
    !refEn |=> !refPend_ff)
    else $error("Refresh pending while disabled");
  count_clear_a: assert property ( // R15
    matchRefresh && !wrCount |=> count_ff == 8'h00)
    else $error("Counter not cleared on match");
  ref_first_a: assert property ( // R18
    state_ff == ST_IDLE && refPend_ff |=> state_ff == ST_RCAS || state_ff == ST_SELF)
    else $error("Access ran before pending refresh");
  match_start_a: assert property ( // R14
    matchRefresh |=> refPend_ff)
    else $error("Match did not start refresh");
  self_mode_a: assert property ( // R10
    state_ff == ST_IDLE && refPend_ff && refModeSel |=> state_ff == ST_SELF)
    else $error("Self refresh not entered");

  cbr_refresh_c: cover property (state_ff == ST_RCAS ##1 state_ff == ST_RRAS);
  self_refresh_c: cover property (state_ff == ST_SELF);
  page_hit_c: cover property (state_ff == ST_PAGE ##1 state_ff == ST_COL);
  flag_clear_c: cover property (matchFlag ##1 !matchFlag);

endmodule : drt_refresh_ctrl

// ### inc/drt_defines.svh
// Register offsets, field positions and reset values of the refresh timer block
`ifndef DRT_DEFINES_SVH
`define DRT_DEFINES_SVH

// ***************************************************
// Register byte offsets
// ***************************************************
`define DRT_OFS_CTRL 32'h0000_0000
`define DRT_OFS_COUNT 32'h0000_0004
`define DRT_OFS_PERIOD 32'h0000_0008
`define DRT_OFS_MEMCTL 32'h0000_000C
`define DRT_OFS_AREA 32'h0000_0010
`define DRT_OFS_ISTAT 32'h0000_0014
`define DRT_OFS_IMASK 32'h0000_0018
`define DRT_OFS_STATE 32'h0000_001C

// ***************************************************
// Field positions
// ***************************************************
`define DRT_CTRL_REFEN 7
`define DRT_CTRL_RWAIT 6
`define DRT_CTRL_RMSEL 5
`define DRT_CTRL_MFLAG 4
`define DRT_CTRL_MIEN 3
`define DRT_MEM_PCL 7
`define DRT_MEM_BURST 6
`define DRT_MEM_RASDOWN 5
`define DRT_IST_MATCH 0
`define DRT_IST_REFRESH 1

// ***************************************************
// Reset values, area codes and cycle counts
// ***************************************************
`define DRT_RST_REG8 8'h00
`define DRT_RST_IRQ2 2'h0
`define DRT_AREA_ORDINARY 2'h0
`define DRT_AREA_DRAM 2'h1
`define DRT_AREA_PSRAM 2'h2
`define DRT_PRE_SHORT 3'h1
`define DRT_PRE_LONG 3'h2
`define DRT_RAS_BASE 3'h1

`endif

// ### inc/drt_pkg.sv
// Types shared by the refresh timer block
package drt_pkg;

  // ***************************************************
  // Sequencer states and carriers
  // ***************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_ROW, ST_COL, ST_PAGE, ST_PRE, ST_RCAS, ST_RRAS, ST_SELF
  } drt_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } drt_apb_req_s;

  typedef struct packed {
    logic rasActive;
    logic casActive;
  } drt_strobe_s;

endpackage : drt_pkg

// ### test/drt_mem_model.sv
// Memory-side model that watches the strobes of the refresh timer block
`timescale 1ns/1ps
module drt_mem_model
  import drt_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire drt_strobe_s memStrobe,
  output int cbrCount,
  output int accCount
);
  // ***************************************************
  // Strobe decoding
  // ***************************************************
  logic rasQ;

  // Column strobe already low when the row strobe falls means refresh, else a row opens
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rasQ <= 1'b0;
      cbrCount <= 0;
      accCount <= 0;
    end else begin
      rasQ <= memStrobe.rasActive;
      if (memStrobe.rasActive && !rasQ && memStrobe.casActive) begin
        cbrCount <= cbrCount + 1;
      end else if (memStrobe.rasActive && !rasQ) begin
        accCount <= accCount + 1;
      end
    end
  end
endmodule : drt_mem_model

// ### test/test_drt_refresh_ctrl.sv
// Self-checking bench for the refresh timer block
`timescale 1ns/1ps
`include "drt_defines.svh"
module test_drt_refresh_ctrl
  import drt_pkg::*;
;
  // ***************************************************
  // Signals and instances
  // ***************************************************
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic accReq = 1'b0;
  drt_apb_req_s req = '0;
  logic pready, pslverr, accAck, refreshBusy, matchIrq, irq, perr, b;
  logic [31:0] prdata, rd, v;
  drt_strobe_s memStrobe;
  int err_count = 0;
  int num_checks = 0;
  int cbrCount, accCount, g, n, d, ww;
  logic [1:0] area;
  logic [31:0] ofs [6] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h18};
  logic [1:0] areas [7] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1};
  logic [7:0] opts [7] = '{8'h20, 8'hA0, 8'h60, 8'h60, 8'h60, 8'hA0, 8'h40};

  // Clock of 4 ns
  always #2 mclk = ~mclk;

  drt_refresh_ctrl uut (.mclk(mclk), .resetn(resetn), .apbReq(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .accReq(accReq), .accAck(accAck),
    .memStrobe(memStrobe), .refreshBusy(refreshBusy), .matchIrq(matchIrq), .irq(irq));
  drt_mem_model mem (.mclk(mclk), .resetn(resetn), .memStrobe(memStrobe),
    .cbrCount(cbrCount), .accCount(accCount));

  // ***************************************************
  // Helpers and expectations
  // ***************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, dat};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    perr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdc

  function automatic logic sig(input int s);
    return (s == 0) ? matchIrq : (s == 1) ? refreshBusy : accAck;
  endfunction : sig

  // Bounded wait for an output level, so a stuck design cannot hang the run
  task automatic waitFor(input int s, input logic lvl, input int lim);
    n = 0;
    while (sig(s) !== lvl && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk(sig(s), lvl);
  endtask : waitFor

  function automatic int gapExp(input logic [1:0] ar, input logic [7:0] op);
    logic mm;
    mm = (ar == `DRT_AREA_DRAM) || (ar == `DRT_AREA_PSRAM);
    if (mm && op[`DRT_MEM_BURST]) return 2;
    return (mm && op[`DRT_MEM_PCL]) ? 5 : 4;
  endfunction : gapExp

  function automatic int busyExp(input logic [1:0] ar, input int w, input logic bb);
    return 2 + ((ar == `DRT_AREA_DRAM) ? w : 0) + bb;
  endfunction : busyExp

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    v = $urandom(32'h9AEC);
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    foreach (ofs[i])
      rdc(ofs[i], 32'hFFFF_FFEF, 32'h0);
    apb(1'b0, 32'h20, 32'h0);
    chk({perr, rd}, {1'b1, 32'h0});
    repeat (4) begin
      v = $urandom & 32'hFF;
      apb(1'b1, `DRT_OFS_COUNT, v);
      rdc(`DRT_OFS_COUNT, 32'hFF, v);
      apb(1'b1, `DRT_OFS_PERIOD, v ^ 32'h5A);
      rdc(`DRT_OFS_PERIOD, 32'hFF, v ^ 32'h5A);
    end
    $display("test registers done");
    // Prescaler codes; stopped code must leave the count alone
    apb(1'b1, `DRT_OFS_PERIOD, 32'hFF);
    for (int c = 0; c < 8; c++) begin
      d = (c == 0) ? 8 : (c == 7) ? 4096 : 1 << (2 * c - 1);
      apb(1'b1, `DRT_OFS_CTRL, c);
      apb(1'b1, `DRT_OFS_COUNT, 32'h0);
      // Slowest codes get fewer periods to keep the run short
      repeat (((c < 6) ? 16 : 2) * d) @(posedge mclk);
      apb(1'b0, `DRT_OFS_COUNT, 32'h0);
      chk((c == 0) ? rd : 32'((c < 6) ? (rd >= 16 && rd <= 18) : (rd >= 2 && rd <= 4)),
        (c == 0) ? 32'h0 : 32'h1);
    end
    $display("test prescaler done");
    // Flag, enable and interrupt; no refresh with enable low
    apb(1'b1, `DRT_OFS_CTRL, 32'h0);
    apb(1'b1, `DRT_OFS_PERIOD, 32'h3);
    apb(1'b1, `DRT_OFS_COUNT, 32'h80);
    apb(1'b0, `DRT_OFS_CTRL, 32'h0);
    apb(1'b1, `DRT_OFS_CTRL, 32'h0);
    apb(1'b1, `DRT_OFS_ISTAT, 32'h3);
    apb(1'b1, `DRT_OFS_IMASK, 32'h1);
    apb(1'b1, `DRT_OFS_COUNT, 32'h0);
    apb(1'b1, `DRT_OFS_CTRL, 32'h9);
    waitFor(0, 1'b1, 60);
    @(negedge mclk);
    chk(irq, 1'b1);
    repeat (20) @(posedge mclk);
    chk(refreshBusy, 1'b0);
    apb(1'b1, `DRT_OFS_CTRL, 32'h8);
    apb(1'b0, `DRT_OFS_COUNT, 32'h0);
    chk(32'(rd > 3), 32'h1);
    chk(matchIrq, 1'b1);
    apb(1'b1, `DRT_OFS_CTRL, 32'h0);
    @(negedge mclk);
    chk(matchIrq, 1'b0);
    rdc(`DRT_OFS_CTRL, 32'hFF, 32'h10);
    apb(1'b1, `DRT_OFS_CTRL, 32'h8);
    rdc(`DRT_OFS_CTRL, 32'hFF, 32'h8);
    apb(1'b1, `DRT_OFS_ISTAT, 32'h1);
    @(negedge mclk);
    chk({irq, matchIrq}, 2'h0);
    apb(1'b1, `DRT_OFS_IMASK, 32'h0);
    apb(1'b1, `DRT_OFS_COUNT, 32'h2);
    apb(1'b1, `DRT_OFS_CTRL, 32'h1);
    repeat (10) @(posedge mclk);
    rdc(`DRT_OFS_ISTAT, 32'h1, 32'h1);
    chk(irq, 1'b0);
    $display("test flag done");
    // Refresh lengths for each wait count, DRAM then pseudo-SRAM
    for (int w = 0; w < 5; w++) begin
      area = (w == 4) ? `DRT_AREA_PSRAM : `DRT_AREA_DRAM;
      ww = w & 3;
      b = (w == 4) ? 1'b0 : 1'($urandom);
      apb(1'b1, `DRT_OFS_CTRL, 32'h0);
      apb(1'b1, `DRT_OFS_AREA, {30'h0, area});
      apb(1'b1, `DRT_OFS_MEMCTL, 32'h20 | ww);
      apb(1'b1, `DRT_OFS_PERIOD, 32'h2);
      apb(1'b1, `DRT_OFS_COUNT, 32'h0);
      apb(1'b1, `DRT_OFS_CTRL, 32'h81 | {25'h0, b, 6'h0});
      waitFor(1, 1'b1, 40);
      g = 0;
      while (refreshBusy === 1'b1 && g < 20) begin
        @(posedge mclk);
        g++;
      end
      chk(g, busyExp(area, ww, b));
      apb(1'b1, `DRT_OFS_CTRL, 32'h0);
      apb(1'b0, `DRT_OFS_COUNT, 32'h0);
      chk(32'(rd < 3), 32'h1);
    end
    chk(32'(cbrCount >= 5), 32'h1);
    apb(1'b1, `DRT_OFS_CTRL, 32'hA1);
    waitFor(1, 1'b1, 40);
    repeat (30) @(posedge mclk);
    chk(refreshBusy, 1'b1);
    apb(1'b1, `DRT_OFS_CTRL, 32'h0);
    waitFor(1, 1'b0, 10);
    $display("test refresh done");
    // Access spacing and row strobe after the requester pauses
    for (int t = 0; t < 7; t++) begin
      apb(1'b1, `DRT_OFS_AREA, {30'h0, areas[t]});
      apb(1'b1, `DRT_OFS_MEMCTL, {24'h0, opts[t]});
      accReq <= 1'b1;
      waitFor(2, 1'b1, 20);
      g = 0;
      do begin
        @(posedge mclk);
        g++;
      end while (accAck !== 1'b1 && g < 20);
      chk(g, gapExp(areas[t], opts[t]));
      accReq <= 1'b0;
      repeat (8) @(posedge mclk);
      chk(memStrobe.rasActive, (gapExp(areas[t], opts[t]) == 2) && !opts[t][5]);
    end
    chk(32'(accCount >= 7), 32'h1);
    $display("test access done");
    stop_test();
  end

  // Watchdog well beyond the longest expected run
  initial begin
    #(4 * 60000);
    err_count++;
    stop_test();
  end
endmodule : test_drt_refresh_ctrl
